//--- rtl/strap_pkg.sv
package strap_pkg;

  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_B2B = 3'h6;
  localparam logic [2:0] ADDR_DEFAULT = 3'h1;
  localparam int BIT_BCAST_OFF = 9;
  localparam int BIT_WAKE_EN = 15;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_AUTONEG = 12;
  localparam int CAPTURE_DELAY = 1;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b11
  } cap_state_e;

  typedef struct packed {
    logic [2:0] mgmt_addr;
    logic bcast_off;
    logic [2:0] if_mode;
    logic wake_en;
    logic isolate;
    logic half_duplex;
    logic autoneg_en;
  } strap_cfg_s;

  typedef struct packed {
    logic bcast_off;
    logic wake_en;
    logic isolate;
    logic half_duplex;
    logic autoneg_en;
  } ctrl_bits_s;

  function automatic logic back_to_back(input logic [2:0] code);
    return code == MODE_B2B;
  endfunction

endpackage

//--- rtl/strap_pin_mux.sv
`timescale 1ns/10ps
module strap_pin_mux
  import strap_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Async reset, low
  input wire logic run, // Reset released, pins become outputs
  input wire logic [10:0] func_out, // Functional pin values
  output logic [10:0] pin_out, // Pin drive value
  output logic [10:0] pin_oe_n // Low while driving
);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_oe_n <= 11'h7ff;
      pin_out <= 11'h000;
    end else begin
      pin_oe_n <= {11{~run}};
      pin_out <= run ? func_out : 11'h000;
    end
  end

endmodule

//--- rtl/strap_config_latch.sv
`timescale 1ns/10ps
module strap_config_latch
  import strap_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Chip reset, low active
  input wire logic [2:0] mgmt_addr_strap, // Address strap pins
  input wire logic bcast_addr_off_strap, // Broadcast-off strap
  input wire logic [2:0] if_mode_strap, // Interface mode straps
  input wire logic wake_out_en_strap, // Wake output enable strap
  input wire logic isolate_strap, // Isolate strap
  input wire logic duplex_strap, // Duplex strap
  input wire logic autoneg_en_strap, // Auto-negotiation strap
  input wire logic ctrl_wr, // Software write strobe
  input wire logic [15:0] ctrl_wdata, // Software write data
  input wire logic [15:0] ctrl_wmask, // Bits written
  input wire logic [3:0] mac_txd, // MAC transmit nibble
  input wire logic mac_txen, // MAC transmit enable
  input wire logic [3:0] line_rxd, // Recovered receive nibble
  input wire logic line_rxdv, // Recovered nibble valid
  input wire logic [10:0] func_out, // Functional values for strap pins
  output logic [10:0] strap_pin_out, // Strap pin drive
  output logic [10:0] strap_pin_oe_n, // Strap pin enable, low drives
  output logic [2:0] mgmt_addr, // Management address
  output logic addr0_broadcast, // Address 0 answers as broadcast
  output logic back_to_back_mode, // Back-to-back selected
  output logic wake_en, // Wake output enabled
  output logic isolate, // Isolate mode
  output logic full_duplex, // Full duplex selected
  output logic autoneg_en, // Auto-negotiation enabled
  output logic wake_event_out_n, // Wake event, low active
  output logic wake_event_oe_n, // Wake pin drive, low drives
  input wire logic wake_event, // Internal wake event
  output logic [3:0] mac_rxd, // Receive nibble to MAC
  output logic mac_rxdv, // Receive valid to MAC
  output logic [3:0] tx_nibble, // Accepted transmit nibble
  output logic tx_nibble_valid, // Transmit nibble accepted
  output logic cfg_ready // Configuration latched
);

  cap_state_e state_reg;
  strap_cfg_s latched_cfg;
  ctrl_bits_s ctrl_reg;
  ctrl_bits_s ctrl_next;
  logic run;
  logic capture_now;
  logic seed_now;
  logic [2:0] snap_addr_reg;
  logic snap_bcast_reg;
  logic [2:0] snap_mode_reg;
  logic snap_wake_reg;
  logic snap_isolate_reg;
  logic snap_half_dup_reg;
  logic snap_autoneg_reg;

  ////////////////////////////////////////////////////////////////////
  // Capture sequence after reset release

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_RESET;
    end else begin
      case (state_reg)
        ST_RESET: state_reg <= ST_CAPTURE;
        ST_CAPTURE: state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_RESET;
      endcase
    end
  end

  // First clock after release samples pins still released as inputs
  assign capture_now = state_reg == ST_RESET;
  assign seed_now = state_reg == ST_CAPTURE;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_addr_reg <= ADDR_DEFAULT;
    end else if (capture_now) begin
      snap_addr_reg <= mgmt_addr_strap;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_bcast_reg <= 1'b0;
    end else if (capture_now) begin
      snap_bcast_reg <= bcast_addr_off_strap;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_mode_reg <= MODE_NORMAL;
    end else if (capture_now) begin
      snap_mode_reg <= if_mode_strap;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_wake_reg <= 1'b0;
    end else if (capture_now) begin
      snap_wake_reg <= wake_out_en_strap;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_isolate_reg <= 1'b0;
    end else if (capture_now) begin
      snap_isolate_reg <= isolate_strap;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_half_dup_reg <= 1'b1;
    end else if (capture_now) begin
      snap_half_dup_reg <= duplex_strap;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_autoneg_reg <= 1'b1;
    end else if (capture_now) begin
      snap_autoneg_reg <= autoneg_en_strap;
    end
  end

  assign latched_cfg = '{mgmt_addr: snap_addr_reg, bcast_off: snap_bcast_reg,
    if_mode: snap_mode_reg, wake_en: snap_wake_reg, isolate: snap_isolate_reg,
    half_duplex: snap_half_dup_reg, autoneg_en: snap_autoneg_reg};

  assign run = state_reg == ST_RUN;
  assign cfg_ready = run;

  ////////////////////////////////////////////////////////////////////
  // Seeded control bits

  always_comb begin
    ctrl_next = ctrl_reg;
    if (seed_now) begin
      ctrl_next.bcast_off = latched_cfg.bcast_off;
      ctrl_next.wake_en = latched_cfg.wake_en;
      ctrl_next.isolate = latched_cfg.isolate;
      ctrl_next.half_duplex = latched_cfg.half_duplex;
      ctrl_next.autoneg_en = latched_cfg.autoneg_en;
    end else if (run && ctrl_wr) begin
      if (ctrl_wmask[BIT_BCAST_OFF] && ctrl_wdata[BIT_BCAST_OFF]) begin
        ctrl_next.bcast_off = 1'b1;
      end
      if (ctrl_wmask[BIT_WAKE_EN]) begin
        ctrl_next.wake_en = ctrl_wdata[BIT_WAKE_EN];
      end
      if (ctrl_wmask[BIT_ISOLATE]) begin
        ctrl_next.isolate = ctrl_wdata[BIT_ISOLATE];
      end
      if (ctrl_wmask[BIT_DUPLEX]) begin
        ctrl_next.half_duplex = ~ctrl_wdata[BIT_DUPLEX];
      end
      if (ctrl_wmask[BIT_AUTONEG]) begin
        ctrl_next.autoneg_en = ctrl_wdata[BIT_AUTONEG];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= '{bcast_off: 1'b0, wake_en: 1'b0, isolate: 1'b0,
                    half_duplex: 1'b1, autoneg_en: 1'b1};
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration outputs

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_addr <= ADDR_DEFAULT;
    end else begin
      mgmt_addr <= latched_cfg.mgmt_addr;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr0_broadcast <= 1'b1;
    end else begin
      addr0_broadcast <= ~ctrl_next.bcast_off;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      back_to_back_mode <= 1'b0;
    end else begin
      back_to_back_mode <= back_to_back(latched_cfg.if_mode);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_en <= 1'b0;
    end else begin
      wake_en <= ctrl_next.wake_en;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      isolate <= 1'b0;
    end else begin
      isolate <= ctrl_next.isolate;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      full_duplex <= 1'b0;
    end else begin
      full_duplex <= ~ctrl_next.half_duplex;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      autoneg_en <= 1'b1;
    end else begin
      autoneg_en <= ctrl_next.autoneg_en;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wake pin, open drain

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_event_out_n <= 1'b1;
    end else begin
      wake_event_out_n <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_event_oe_n <= 1'b1;
    end else begin
      wake_event_oe_n <= ~(run && ctrl_next.wake_en && wake_event);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Nibble paths

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mac_rxdv <= 1'b0;
    end else begin
      mac_rxdv <= run && line_rxdv;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mac_rxd <= 4'h0;
    end else begin
      mac_rxd <= (run && line_rxdv) ? line_rxd : 4'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_nibble_valid <= 1'b0;
    end else begin
      tx_nibble_valid <= run && mac_txen;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_nibble <= 4'h0;
    end else begin
      tx_nibble <= (run && mac_txen) ? mac_txd : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Strap pin direction

  strap_pin_mux u_pin_mux (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(run),
    .func_out(func_out),
    .pin_out(strap_pin_out),
    .pin_oe_n(strap_pin_oe_n)
  );

endmodule

//--- verif/strap_config_latch_monitor.sv
`timescale 1ns/10ps
module strap_config_latch_monitor
  import strap_pkg::*;
(
  input logic sys_clk, reset_n, cfg_ready, // Clock, reset, ready
  input logic [2:0] mgmt_addr_strap, if_mode_strap, mgmt_addr, // Straps, address
  input logic bcast_addr_off_strap, wake_out_en_strap, isolate_strap, // Straps
  input logic duplex_strap, autoneg_en_strap, ctrl_wr, // Straps, write
  input logic [15:0] ctrl_wdata, ctrl_wmask, // Write data, mask
  input logic [3:0] mac_txd, line_rxd, mac_rxd, tx_nibble, // Nibbles
  input logic mac_txen, line_rxdv, mac_rxdv, tx_nibble_valid, // Valids
  input logic [10:0] strap_pin_oe_n, // Pin enables
  input logic addr0_broadcast, back_to_back_mode, wake_en, isolate, // Config
  input logic full_duplex, autoneg_en, wake_event, wake_event_oe_n // Wake
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_capture;
    !cfg_ready ##1 cfg_ready;
  endsequence
  sequence s_write(b);
    cfg_ready && ctrl_wr && ctrl_wmask[b];
  endsequence
  cap_value_a: assert property ($rose(cfg_ready) |->
    {mgmt_addr, addr0_broadcast, wake_en, isolate, full_duplex, autoneg_en} == $past({mgmt_addr_strap,
    !bcast_addr_off_strap, wake_out_en_strap, isolate_strap, !duplex_strap, autoneg_en_strap}, 2))
    else $error("Latched configuration differs from straps");
  mode_decode_a: assert property ($rose(cfg_ready) |->
    back_to_back_mode == ($past(if_mode_strap, 2) == MODE_B2B)) else $error("Mode decode wrong");
  pins_input_a: assert property (!cfg_ready |-> strap_pin_oe_n == 11'h7ff)
    else $error("Strap pin driven during reset");
  pins_drive_a: assert property (s_capture |=> strap_pin_oe_n == 11'h000)
    else $error("Strap pins not driven after release");
  cfg_hold_a: assert property (cfg_ready |=> $stable(mgmt_addr) && $stable(back_to_back_mode))
    else $error("Latched address changed");
  bcast_set_a: assert property (s_write(9) ##0 ctrl_wdata[9] |=> !addr0_broadcast)
    else $error("Broadcast-off write ignored");
  bcast_sticky_a: assert property (!addr0_broadcast |=> !addr0_broadcast)
    else $error("Broadcast-off cleared");
  dup_write_a: assert property (s_write(8) |=> full_duplex == $past(ctrl_wdata[8]))
    else $error("Duplex write not applied");
  rx_pass_a: assert property (cfg_ready && line_rxdv |=> mac_rxdv && mac_rxd == $past(line_rxd))
    else $error("Receive nibble not passed");
  rx_idle_a: assert property (!mac_rxdv |-> mac_rxd == 4'h0)
    else $error("Receive data without valid");
  tx_pass_a: assert property (cfg_ready |=> tx_nibble_valid == $past(mac_txen) &&
    (!tx_nibble_valid || tx_nibble == $past(mac_txd))) else $error("Transmit nibble wrong");
  wake_pin_a: assert property (cfg_ready && wake_event && wake_en |=> !wake_event_oe_n)
    else $error("Wake pin not pulled");
endmodule
bind strap_config_latch strap_config_latch_monitor mon (.sys_clk, .reset_n, .cfg_ready,
  .mgmt_addr_strap, .if_mode_strap, .mgmt_addr, .bcast_addr_off_strap, .wake_out_en_strap,
  .isolate_strap, .duplex_strap, .autoneg_en_strap, .ctrl_wr, .ctrl_wdata, .ctrl_wmask, .mac_txd,
  .line_rxd, .mac_rxd, .tx_nibble, .mac_txen, .line_rxdv, .mac_rxdv, .tx_nibble_valid,
  .strap_pin_oe_n, .addr0_broadcast, .back_to_back_mode, .wake_en, .isolate, .full_duplex,
  .autoneg_en, .wake_event, .wake_event_oe_n);

//--- verif/strap_board_model.sv
`timescale 1ns/10ps
module strap_board_model
  import strap_pkg::*;
(
  input logic sys_clk, // Clock
  input logic reset_n, // Chip reset
  input strap_cfg_s cfg, // Resistor levels
  output strap_cfg_s strap, // Strap pin levels
  output logic [3:0] mac_txd, // MAC nibble
  output logic mac_txen // MAC enable
);
  logic moved;
  logic [3:0] k;
  // Straps drift after the first edge; only the capture edge may count
  assign strap = moved ? ~cfg : cfg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      moved <= 1'b0;
      k <= 4'h0;
      mac_txen <= 1'b0;
      mac_txd <= 4'h0;
    end else begin
      moved <= 1'b1;
      k <= k + 4'h1;
      mac_txen <= k[1];
      mac_txd <= k[1] ? k : ~mac_txd;
    end
  end
endmodule

//--- verif/tb_strap_config_latch.sv
`timescale 1ns/10ps
module tb_strap_config_latch;
  import strap_pkg::*;
  logic sys_clk = 0, reset_n = 0, ctrl_wr = 0, line_rxdv = 0, wake_event = 0, pv;
  logic [4:0] pt;
  logic [15:0] ctrl_wdata = 0, ctrl_wmask = 0;
  logic [3:0] line_rxd = 0, mac_txd, mac_rxd, tx_nibble, pd;
  logic [10:0] func_out = 0, strap_pin_out, strap_pin_oe_n;
  logic [2:0] mgmt_addr;
  logic addr0_broadcast, back_to_back_mode, wake_en, isolate, full_duplex, autoneg_en;
  logic wake_event_out_n, wake_event_oe_n, mac_rxdv, tx_nibble_valid, cfg_ready, mac_txen;
  logic [8:0] obs, e;
  strap_cfg_s cfg = 0, strap, c;
  int err_count = 0, checks_done = 0, cyc = 0;
  assign obs = {mgmt_addr, addr0_broadcast, back_to_back_mode, wake_en, isolate, full_duplex,
    autoneg_en};
  always #2 sys_clk = ~sys_clk;
  strap_board_model board (.sys_clk, .reset_n, .cfg, .strap, .mac_txd, .mac_txen);
  strap_config_latch uut (.sys_clk, .reset_n, .mgmt_addr_strap(strap.mgmt_addr),
    .bcast_addr_off_strap(strap.bcast_off), .if_mode_strap(strap.if_mode),
    .wake_out_en_strap(strap.wake_en), .isolate_strap(strap.isolate),
    .duplex_strap(strap.half_duplex), .autoneg_en_strap(strap.autoneg_en), .ctrl_wr, .ctrl_wdata,
    .ctrl_wmask, .mac_txd, .mac_txen, .line_rxd, .line_rxdv, .func_out, .strap_pin_out,
    .strap_pin_oe_n, .mgmt_addr, .addr0_broadcast, .back_to_back_mode, .wake_en, .isolate,
    .full_duplex, .autoneg_en, .wake_event_out_n, .wake_event_oe_n, .wake_event, .mac_rxd,
    .mac_rxdv, .tx_nibble, .tx_nibble_valid, .cfg_ready);
  task finish_test;
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [20:0] got, input logic [20:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task boot(input strap_cfg_s s);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    cfg <= s;
    repeat (12) @(posedge sys_clk);
    chk({obs, cfg_ready, strap_pin_oe_n}, {9'h061, 1'b0, 11'h7ff});
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
  task wr(input logic [15:0] d, input logic [15:0] m);
    @(posedge sys_clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= d;
    ctrl_wmask <= m;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 7; i >= 0; i--) begin
      c = strap_cfg_s'({i[2:0] ^ 3'h1, i[0], i[2:0], i[1], i[2], ~i[0], ~i[1]});
      boot(c);
      e = {c.mgmt_addr, !c.bcast_off, c.if_mode == MODE_B2B, c.wake_en, c.isolate,
        !c.half_duplex, c.autoneg_en};
      chk({obs, cfg_ready, strap_pin_oe_n}, {e, 1'b1, 11'h000});
      chk(21'({obs, wake_event_out_n, wake_event_oe_n}), 21'({e, 2'b01}));
    end
    func_out <= 11'h5a5;
    wr(16'h8700, 16'h9700);
    wr(16'h0000, 16'h9700);
    @(posedge sys_clk);
    ctrl_wr <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(21'(obs), 21'(9'h040));
    chk(21'(strap_pin_out), 21'(11'h5a5));
    pv = 1'b0;
    pd = 4'h0;
    pt = {mac_txen, mac_txd};
    for (int k = 1; k < 8; k++) begin
      @(posedge sys_clk);
      line_rxdv <= k[0];
      line_rxd <= 4'(k * 3);
      #1;
      chk(21'({mac_rxdv, mac_rxd}), 21'({pv, pv ? pd : 4'h0}));
      chk(21'({tx_nibble_valid, tx_nibble}), 21'({pt[4], pt[4] ? pt[3:0] : 4'h0}));
      pv = k[0];
      pd = 4'(k * 3);
      pt = {mac_txen, mac_txd};
    end
    wr(16'h8000, 16'h8000);
    @(posedge sys_clk);
    ctrl_wr <= 1'b0;
    wake_event <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(21'({obs, wake_event_oe_n}), 21'({9'h048, 1'b0}));
    finish_test;
  end
endmodule
